// ==== hw/front_panel.sv ====
// Front-panel lamps, boot sequencing and option switch capture
`timescale 1ns/1ns
`include "panel_consts.svh"

module front_panel #(
  parameter int unsigned CHECK_CYC = `CHECK_CYC,
  parameter int unsigned START_CYC = `START_CYC,
  parameter int unsigned ACT_CYC = `ACT_CYC,
  parameter int unsigned FLASH_ON_CYC = `FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF_CYC = `FLASH_OFF_CYC,
  parameter int unsigned FLASH_PAUSE_CYC = `FLASH_PAUSE_CYC,
  parameter bit LARGE_VARIANT = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic supply_ok_i,
  input wire logic io_power_i,
  input wire logic rx_act_i,
  input wire logic tx_act_i,
  input wire logic link_100_i,
  input wire logic check_fail_i,
  input wire logic configured_i,
  input wire logic [7:0] option_sw_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic power_lamp_o,
  output logic status_lamp_o,
  output logic link_activity_lamp_o,
  output logic speed_lamp_o,
  output panel_pkg::lamp_t [3:0] user_lamp_o,
  output logic module_ready_o,
  output logic net_enable_o,
  output logic io_access_o,
  output logic runtime_start_o,
  output logic user_prog_en_o,
  output logic network_address_reset_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic panel_pkg::boot_opts_t pick_opt(
    input logic [2:0] sw
  );
    panel_pkg::boot_opts_t o;
    o = '0;
    if (sw[0]) begin
      o.inhibit = 1'b1;
    end else if (sw[1]) begin
      o.recovery = 1'b1;
    end else if (sw[2]) begin
      o.addr_reset = 1'b1;
    end
    return o;
  endfunction

  function automatic panel_pkg::lamp_t lamp_dec(
    input logic [1:0] v,
    input logic is_a
  );
    panel_pkg::lamp_t l;
    l = '0;
    if (v == `LAMP_GREEN) begin
      l.green = 1'b1;
    end else if (v == `LAMP_RED) begin
      // Lamp A has no red drive; 2 shows as green
      l.green = is_a;
      l.red = !is_a;
    end
    return l;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  panel_pkg::boot_state_t state_ff;
  logic [31:0] seq_cnt_ff;
  logic sampled_ff;
  panel_pkg::boot_opts_t opts_ff;
  logic [7:0] user_led_ff;
  logic [3:0] err_code_ff;
  logic [3:0] flash_code;
  logic [3:0] flash_cnt_ff;
  logic [31:0] flash_tmr_ff;
  logic flash_on_ff;
  logic flash_pause_ff;
  logic [31:0] act_tmr_ff;
  logic [31:0] rd_mux;
  logic [4:0] user_sw;
  logic [3:0] rs485_map;

  // ****************************************************************
  // Boot sequence
  // ****************************************************************
  // Self test never touches the link; only a failure drops it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= panel_pkg::ST_CHECK;
      seq_cnt_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        panel_pkg::ST_CHECK: begin
          if (seq_cnt_ff == CHECK_CYC - 1) begin
            seq_cnt_ff <= 32'h0000_0000;
            if (check_fail_i) begin
              state_ff <= panel_pkg::ST_FAIL;
            end else if (configured_i) begin
              state_ff <= panel_pkg::ST_START;
            end else begin
              state_ff <= panel_pkg::ST_UNCONF;
            end
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 32'h0000_0001;
          end
        end
        panel_pkg::ST_UNCONF: begin
          if (configured_i) begin
            state_ff <= panel_pkg::ST_START;
          end
        end
        panel_pkg::ST_START: begin
          if (seq_cnt_ff == START_CYC - 1) begin
            seq_cnt_ff <= 32'h0000_0000;
            state_ff <= panel_pkg::ST_RUN;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 32'h0000_0001;
          end
        end
        panel_pkg::ST_RUN: begin
          state_ff <= panel_pkg::ST_RUN;
        end
        panel_pkg::ST_FAIL: begin
          state_ff <= panel_pkg::ST_FAIL;
        end
      endcase
    end
  end

  // ****************************************************************
  // Boot option capture
  // ****************************************************************
  // Caught once at the first edge after release, never again
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sampled_ff <= 1'b0;
      opts_ff <= '0;
    end else if (!sampled_ff) begin
      sampled_ff <= 1'b1;
      opts_ff <= pick_opt(option_sw_i[7:5]);
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      user_led_ff <= 8'h00;
      err_code_ff <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == `REG_USER_LED) begin
        user_led_ff <= wdata_i[7:0];
      end
      if (addr_i == `REG_ERR_CODE) begin
        err_code_ff <= wdata_i[3:0];
      end
    end
  end

  assign user_sw = {option_sw_i[4:2],
                    option_sw_i[1:0] & {2{!LARGE_VARIANT}}};

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      // Port index gp is serial channel gp+1
      assign rs485_map[gp] = (gp == `RS485_PORT);
    end
  endgenerate

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_i)
      `REG_USER_LED: rd_mux[7:0] = user_led_ff;
      `REG_ERR_CODE: rd_mux[3:0] = err_code_ff;
      `REG_STATUS: begin
        rd_mux[4:0] = user_sw;
        rd_mux[7:5] = opts_ff;
        rd_mux[8] = (state_ff == panel_pkg::ST_FAIL);
        rd_mux[9] = module_ready_o;
        rd_mux[10] = link_100_i;
      end
      `REG_PORT_INFO: begin
        rd_mux[3:0] = rs485_map;
        rd_mux[15:8] = `MAX_BANKS;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Status flash engine
  // ****************************************************************
  always_comb begin
    unique case (state_ff)
      panel_pkg::ST_FAIL: flash_code = `CHECK_FAIL_CODE;
      panel_pkg::ST_UNCONF: flash_code = `UNCONF_CODE;
      panel_pkg::ST_RUN: flash_code = err_code_ff;
      default: flash_code = 4'h0;
    endcase
  end

  // A code change mid-group takes effect in that group; code 0 clears it at once
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_cnt_ff <= 4'h0;
      flash_tmr_ff <= 32'h0000_0000;
      flash_on_ff <= 1'b0;
      flash_pause_ff <= 1'b0;
    end else if (flash_code == 4'h0) begin
      flash_cnt_ff <= 4'h0;
      flash_tmr_ff <= 32'h0000_0000;
      flash_on_ff <= 1'b0;
      flash_pause_ff <= 1'b0;
    end else if (flash_tmr_ff != 32'h0000_0000) begin
      flash_tmr_ff <= flash_tmr_ff - 32'h0000_0001;
    end else if (flash_on_ff) begin
      flash_on_ff <= 1'b0;
      flash_tmr_ff <= FLASH_OFF_CYC - 1;
    end else if (flash_pause_ff) begin
      flash_pause_ff <= 1'b0;
    end else if (flash_cnt_ff >= flash_code) begin
      flash_cnt_ff <= 4'h0;
      flash_pause_ff <= 1'b1;
      flash_tmr_ff <= FLASH_PAUSE_CYC - 1;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 4'h1;
      flash_on_ff <= 1'b1;
      flash_tmr_ff <= FLASH_ON_CYC - 1;
    end
  end

  // ****************************************************************
  // Link activity stretch
  // ****************************************************************
  // Stretched so a single frame stays visible to the eye
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_tmr_ff <= 32'h0000_0000;
    end else if (rx_act_i || tx_act_i) begin
      act_tmr_ff <= ACT_CYC - 1;
    end else if (act_tmr_ff != 32'h0000_0000) begin
      act_tmr_ff <= act_tmr_ff - 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Lamp and control outputs
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_lamp_o <= 1'b0;
      status_lamp_o <= 1'b0;
      link_activity_lamp_o <= 1'b0;
      speed_lamp_o <= 1'b0;
    end else begin
      power_lamp_o <= supply_ok_i && io_power_i;
      status_lamp_o <= (state_ff == panel_pkg::ST_CHECK)
                       || flash_on_ff;
      link_activity_lamp_o <= rx_act_i || tx_act_i
                              || (act_tmr_ff != 32'h0000_0000);
      speed_lamp_o <= link_100_i;
    end
  end

  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lamp
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          user_lamp_o[gl] <= '0;
        end else if (state_ff == panel_pkg::ST_START) begin
          user_lamp_o[gl] <= lamp_dec(`LAMP_GREEN, 1'b0);
        end else if (state_ff == panel_pkg::ST_RUN) begin
          user_lamp_o[gl] <= lamp_dec(user_led_ff[2*gl +: 2],
                                      gl == 0);
        end else begin
          user_lamp_o[gl] <= '0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      module_ready_o <= 1'b0;
      net_enable_o <= 1'b0;
      io_access_o <= 1'b0;
      runtime_start_o <= 1'b0;
      user_prog_en_o <= 1'b0;
      network_address_reset_o <= 1'b0;
    end else begin
      module_ready_o <= state_ff == panel_pkg::ST_RUN;
      net_enable_o <= state_ff != panel_pkg::ST_FAIL;
      io_access_o <= (state_ff == panel_pkg::ST_RUN)
                     && !opts_ff.recovery;
      runtime_start_o <= (state_ff == panel_pkg::ST_START
                          || state_ff == panel_pkg::ST_RUN)
                         && !opts_ff.recovery;
      user_prog_en_o <= (state_ff == panel_pkg::ST_RUN)
                        && !opts_ff.recovery
                        && !opts_ff.inhibit;
      network_address_reset_o <= opts_ff.addr_reset;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_power;
    @(posedge core_clk_i) disable iff (rst_i)
    !(supply_ok_i && io_power_i) |=> !power_lamp_o;
  endproperty
  a_power: assert property (p_power)
    else $error("power lamp lit without good supply");

  property p_status_dark;
    @(posedge core_clk_i) disable iff (rst_i)
    (state_ff == panel_pkg::ST_RUN && err_code_ff == 4'h0) [*2]
      |=> !status_lamp_o;
  endproperty
  a_status_dark: assert property (p_status_dark)
    else $error("status lamp lit with no error");

  property p_activity;
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(rx_act_i || tx_act_i) |=> link_activity_lamp_o [*2];
  endproperty
  a_activity: assert property (p_activity)
    else $error("activity lamp did not light");

  property p_speed;
    @(posedge core_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> speed_lamp_o == $past(link_100_i);
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed lamp disagrees with link rate");

  property p_lamp_b_red;
    @(posedge core_clk_i) disable iff (rst_i)
    (state_ff == panel_pkg::ST_RUN && user_led_ff[3:2] == `LAMP_RED)
      |=> user_lamp_o[1].red && !user_lamp_o[1].green;
  endproperty
  a_lamp_b_red: assert property (p_lamp_b_red)
    else $error("lamp B not red for value 2");

  property p_lamp_a_two;
    @(posedge core_clk_i) disable iff (rst_i)
    (state_ff == panel_pkg::ST_RUN && user_led_ff[1:0] == `LAMP_RED)
      |=> user_lamp_o[0].green && !user_lamp_o[0].red;
  endproperty
  a_lamp_a_two: assert property (p_lamp_a_two)
    else $error("lamp A did not show 2 as green");

  property p_fail_off_net;
    @(posedge core_clk_i) disable iff (rst_i)
    state_ff == panel_pkg::ST_FAIL |=> !net_enable_o;
  endproperty
  a_fail_off_net: assert property (p_fail_off_net)
    else $error("network enabled after self test failure");

  property p_opts_frozen;
    @(posedge core_clk_i) disable iff (rst_i)
    sampled_ff |=> $stable(opts_ff);
  endproperty
  a_opts_frozen: assert property (p_opts_frozen)
    else $error("boot options changed after capture");

  property p_one_opt;
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(sampled_ff) |-> $countones(opts_ff) <= 1;
  endproperty
  a_one_opt: assert property (p_one_opt)
    else $error("more than one boot option honoured");

  property p_recovery;
    @(posedge core_clk_i) disable iff (rst_i)
    opts_ff.recovery |=> !io_access_o && !runtime_start_o;
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("recovery boot left runtime or I/O enabled");

  property p_start_lamps;
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(state_ff == panel_pkg::ST_START)
      |=> user_lamp_o[3].green && !module_ready_o;
  endproperty
  a_start_lamps: assert property (p_start_lamps)
    else $error("user lamps not lit during startup");

endmodule

// ==== hw/panel_consts.svh ====
// Constants for the front-panel supervision block
// ****************************************************************
// Overview of operation
// - Power lamp lit while supply good and delivering
// - Status dark normally, errors flash counted groups
// - Activity lamp blinks on Ethernet receive or transmit
// - Speed lamp lit at 100, dark at 10
// - User lamps B-D: 0 off, 1 green, 2 red
// - User lamp A shows value 2 as 1
// - Self test runs seconds, network left undisturbed
// - Failed self test keeps device off the network
// - Self test failure flashed on status lamp
// - Power/status five seconds, user lamps fifteen, ready
// - Switches 3-5 readable, no built-in effect
// - Switches 1-2 readable, disabled on largest variant
// - Switches 6-8 sampled only at boot
// - Several boot switches on: lowest one wins
// - Inhibit switch stops user program at startup
// - Recovery boot: no runtime, no I/O data
// - Address reset switch restores network settings
// - Serial channels one to four are ports 0-3
// - Channels one-three RS-232, channel four RS-485
// - Up to 24 remote banks over RS-485
// ****************************************************************
`ifndef PANEL_CONSTS_SVH
`define PANEL_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ 10000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define CHECK_TIME_MS 5000
`define CHECK_CYC (`CHECK_TIME_MS * `CYC_PER_MS)
`define START_TIME_MS 15000
`define START_CYC (`START_TIME_MS * `CYC_PER_MS)
`define ACT_TIME_MS 30
`define ACT_CYC (`ACT_TIME_MS * `CYC_PER_MS)
`define FLASH_ON_MS 250
`define FLASH_ON_CYC (`FLASH_ON_MS * `CYC_PER_MS)
`define FLASH_OFF_MS 250
`define FLASH_OFF_CYC (`FLASH_OFF_MS * `CYC_PER_MS)
`define FLASH_PAUSE_MS 1500
`define FLASH_PAUSE_CYC (`FLASH_PAUSE_MS * `CYC_PER_MS)

// ****************************************************************
// Register map and fields
// ****************************************************************
`define REG_USER_LED 4'h0
`define REG_ERR_CODE 4'h1
`define REG_STATUS 4'h2
`define REG_PORT_INFO 4'h3
`define LAMP_OFF 2'h0
`define LAMP_GREEN 2'h1
`define LAMP_RED 2'h2
`define CHECK_FAIL_CODE 4'h3
`define UNCONF_CODE 4'h1
`define RS485_PORT 2'h3
`define MAX_BANKS 8'h18

`endif

// ==== hw/panel_pkg.sv ====
// Types shared by the front-panel supervision block
package panel_pkg;

  typedef enum logic [2:0] {
    ST_CHECK,
    ST_UNCONF,
    ST_START,
    ST_RUN,
    ST_FAIL
  } boot_state_t;

  typedef struct packed {
    logic addr_reset;
    logic recovery;
    logic inhibit;
  } boot_opts_t;

  typedef struct packed {
    logic red;
    logic green;
  } lamp_t;

endpackage

// ==== test/net_link_model.sv ====
// Far side of the network port: Ethernet activity and link speed
`timescale 1ns/1ns
module net_link_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic burst_i,
  input wire logic dir_i,
  input wire logic slow_i,
  input wire logic fast_i,
  output logic rx_act_o,
  output logic tx_act_o,
  output logic link_100_o
);
  logic [2:0] left_ff;
  logic dir_ff;

  // Four-wire use: a transmit never echoes back onto receive
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      left_ff <= 3'h0;
      dir_ff <= 1'b0;
    end else if (burst_i) begin
      left_ff <= slow_i ? 3'h6 : 3'h2;
      dir_ff <= dir_i;
    end else if (left_ff != 3'h0) begin
      left_ff <= left_ff - 3'h1;
    end
  end

  assign rx_act_o = left_ff != 3'h0 && !dir_ff;
  assign tx_act_o = left_ff != 3'h0 && dir_ff;
  assign link_100_o = fast_i;
endmodule

// ==== test/front_panel_bench.sv ====
// Self-checking bench for the front-panel supervision block
`timescale 1ns/1ns
module front_panel_bench;
  localparam int CK = 20;
  localparam int ACT = 4;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_ok_i = 1'b1;
  logic io_power_i = 1'b1;
  logic check_fail_i = 1'b0;
  logic configured_i = 1'b1;
  logic [7:0] option_sw_i = 8'h00;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic burst_i = 1'b0;
  logic dir_i = 1'b0;
  logic slow_i = 1'b0;
  logic fast_i = 1'b1;
  logic rx_act, tx_act, link_100;
  logic [31:0] rdata_o;
  logic power_lamp_o, status_lamp_o, link_activity_lamp_o, speed_lamp_o;
  logic module_ready_o, net_enable_o, io_access_o, runtime_start_o;
  logic user_prog_en_o, network_address_reset_o;
  panel_pkg::lamp_t [3:0] user_lamp_o;
  int bad_count = 0;
  int checks = 0;
  logic [7:0] lfsr = 8'h1c;

  always #50 core_clk_i = ~core_clk_i;

  net_link_model net_link_model_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .burst_i(burst_i), .dir_i(dir_i), .slow_i(slow_i),
    .fast_i(fast_i), .rx_act_o(rx_act), .tx_act_o(tx_act),
    .link_100_o(link_100));

  front_panel #(.CHECK_CYC(CK), .START_CYC(30), .ACT_CYC(ACT),
    .FLASH_ON_CYC(3), .FLASH_OFF_CYC(3), .FLASH_PAUSE_CYC(10),
    .LARGE_VARIANT(1'b0)) front_panel_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .supply_ok_i(supply_ok_i), .io_power_i(io_power_i),
    .rx_act_i(rx_act), .tx_act_i(tx_act), .link_100_i(link_100),
    .check_fail_i(check_fail_i), .configured_i(configured_i),
    .option_sw_i(option_sw_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .power_lamp_o(power_lamp_o), .status_lamp_o(status_lamp_o),
    .link_activity_lamp_o(link_activity_lamp_o),
    .speed_lamp_o(speed_lamp_o), .user_lamp_o(user_lamp_o),
    .module_ready_o(module_ready_o), .net_enable_o(net_enable_o),
    .io_access_o(io_access_o), .runtime_start_o(runtime_start_o),
    .user_prog_en_o(user_prog_en_o),
    .network_address_reset_o(network_address_reset_o));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  function automatic logic [1:0] lamp(input logic [1:0] v, input logic a);
    if (v == 2'h2 && a) return 2'h1;
    return (v == 2'h3) ? 2'h0 : v;
  endfunction

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic boot(input logic [7:0] sw, input logic f, input logic c);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    option_sw_i <= sw;
    check_fail_i <= f;
    configured_i <= c;
    cyc(1);
    cmp(32'({power_lamp_o, net_enable_o, status_lamp_o}), 32'h0);
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    cyc(2);
    cmp(32'({net_enable_o, status_lamp_o}), 32'h3);
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 200 && module_ready_o !== 1'b1; i++) cyc(1);
    cmp(32'(module_ready_o), 32'h1);
  endtask

  // Counts one whole flash group, framed by the long dark pauses
  task automatic flashes(output int n);
    int i;
    int dark;
    logic prev;
    dark = 0;
    n = 0;
    prev = 1'b0;
    for (i = 0; i < 300 && dark < 8; i++) begin
      cyc(1);
      dark = status_lamp_o ? 0 : dark + 1;
    end
    dark = 0;
    for (i = 0; i < 300 && (n == 0 || dark < 8); i++) begin
      cyc(1);
      if (status_lamp_o === 1'b1 && !prev) n++;
      prev = status_lamp_o;
      dark = status_lamp_o ? 0 : dark + 1;
    end
  endtask

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [7:0] v;
    logic [7:0] e;
    int n;
    int k;
    boot(8'hd6, 1'b0, 1'b1);
    rd(4'h2, d);
    cmp(d, 32'h0000_0456);
    @(posedge core_clk_i);
    option_sw_i <= 8'h36;
    rd(4'h2, d);
    cmp(d, 32'h0000_0456);
    cyc(CK);
    cmp(32'(user_lamp_o), 32'h0000_0055);
    cmp(32'({status_lamp_o, module_ready_o}), 32'h0);
    wait_ready();
    cmp(32'(user_lamp_o), 32'h0);
    cmp(32'({io_access_o, runtime_start_o, user_prog_en_o}), 32'h0);
    $display("test recovery boot done");

    boot(8'he0, 1'b0, 1'b1);
    wait_ready();
    cmp(32'({io_access_o, runtime_start_o, user_prog_en_o,
      network_address_reset_o}), 32'hc);
    v = 8'haa;
    for (k = 0; k < 8; k++) begin
      wr(4'h0, 32'(v));
      cyc(2);
      e = {lamp(v[7:6], 0), lamp(v[5:4], 0), lamp(v[3:2], 0),
        lamp(v[1:0], 1)};
      cmp(32'(user_lamp_o), 32'(e));
      lfsr = nxt(lfsr);
      v = (k == 0) ? 8'hff : lfsr;
    end
    for (k = 1; k < 4; k++) begin
      wr(4'h1, 32'(k));
      flashes(n);
      cmp(32'(n), 32'(k));
    end
    wr(4'h1, 32'h0);
    cyc(3);
    cmp(32'(status_lamp_o), 32'h0);
    rd(4'h3, d);
    cmp(d, 32'h0000_1808);
    rd(4'h9, d);
    cmp(d, 32'h0);
    for (k = 0; k < 2; k++) begin
      @(posedge core_clk_i);
      burst_i <= 1'b1;
      dir_i <= k[0];
      slow_i <= k[0];
      @(posedge core_clk_i);
      burst_i <= 1'b0;
      cyc(2);
      cmp(32'(link_activity_lamp_o), 32'h1);
      cyc(ACT + 8);
      cmp(32'(link_activity_lamp_o), 32'h0);
    end
    @(posedge core_clk_i);
    fast_i <= 1'b0;
    cyc(3);
    cmp(32'(speed_lamp_o), 32'h0);
    @(posedge core_clk_i);
    fast_i <= 1'b1;
    io_power_i <= 1'b0;
    cyc(3);
    cmp(32'({speed_lamp_o, power_lamp_o}), 32'h2);
    @(posedge core_clk_i);
    io_power_i <= 1'b1;
    cyc(3);
    cmp(32'(power_lamp_o), 32'h1);
    $display("test run mode done");

    boot(8'h80, 1'b0, 1'b0);
    cmp(32'(network_address_reset_o), 32'h1);
    flashes(n);
    cmp(32'(n), 32'h1);
    @(posedge core_clk_i);
    configured_i <= 1'b1;
    wait_ready();
    cmp(32'({runtime_start_o, user_prog_en_o}), 32'h3);
    $display("test unconfigured boot done");

    boot(8'h00, 1'b1, 1'b1);
    cyc(CK);
    cmp(32'({net_enable_o, module_ready_o}), 32'h0);
    flashes(n);
    cmp(32'(n), 32'h3);
    $display("test failed self test done");
    stop_test();
  end

  initial begin
    #(100 * 20000);
    cmp(32'h0, 32'h1);
    stop_test();
  end
endmodule
